// ===== common/lkd_params.svh
// constants of the link key derivation engine
`ifndef LKD_PARAMS_SVH
`define LKD_PARAMS_SVH
`define LKD_KEY_W      128
`define LKD_ADDR_W     48
`define LKD_OFS_W      96
`define LKD_LEN_W      5
`define LKD_MASTER_LEN 5'h10
`define LKD_ZERO_KEY   128'h0000_0000_0000_0000_0000_0000_0000_0000
`define LKD_ZERO_OFS   96'h0000_0000_0000_0000_0000_0000
`define LKD_ZERO_ADDR  48'h0000_0000_0000
`endif

// ===== common/lkd_pkg.sv
// types shared by both ends of the key derivation link
`include "lkd_params.svh"
package lkd_pkg;
	typedef logic [`LKD_KEY_W-1:0]  key_t;
	typedef logic [`LKD_ADDR_W-1:0] addr_t;
	typedef logic [`LKD_OFS_W-1:0]  ofs_t;
	typedef enum logic [2:0] {
		MSG_NONE, MSG_UNIT_KEY, MSG_COMB_RAND, MSG_MASTER_RAND,
		MSG_MASTER_KEY, MSG_USE_MASTER, MSG_ENC_RAND, MSG_FALLBACK
	} msg_t;
	// stand-in mixing used for the key functions; the real functions sit outside
	function automatic key_t mixKey(input key_t a, input key_t b);
		mixKey = {a[`LKD_KEY_W-14:0], a[`LKD_KEY_W-1:`LKD_KEY_W-13]} ^ b ^ {a[63:0], b[127:64]};
	endfunction : mixKey
endpackage : lkd_pkg

// ===== common/lkd_link_if.sv
// message link joining the two key derivation ends
`timescale 1ns/1ps
interface lkd_link_if (
	input wire logic clk
);
	import lkd_pkg::*;
	// device to peer
	msg_t dMsg;
	key_t dData;
	// peer to device
	msg_t pMsg;
	key_t pData;
	modport device (output dMsg, output dData, input pMsg, input pData);
	modport peer   (input dMsg, input dData, output pMsg, output pData);
endinterface : lkd_link_if

// ===== core/lkd_device_end.sv
// device end: link key store, combination, master key and encryption key logic
`timescale 1ns/1ps
module lkd_device_end
	import lkd_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link toward the peer
	lkd_link_if.device link,
	// link manager commands, one-cycle pulses
	input  wire logic cmdUnitKey,
	input  wire logic cmdComb,
	input  wire logic cmdMasterGen,
	input  wire logic cmdUseMaster,
	input  wire logic cmdEncrypt,
	input  wire logic cmdFallback,
	input  wire logic authDone,
	input  wire logic authOk,
	input  wire logic authConfirm,
	input  wire logic lenOk,
	// link manager data
	input  wire key_t initKey,
	input  wire key_t unitKey,
	input  wire key_t randIn,
	input  wire addr_t ownAddr,
	input  wire addr_t peerAddr,
	input  wire addr_t masterAddr,
	input  wire ofs_t authOffset,
	input  wire logic isMaster,
	// results
	output key_t linkKey,
	output logic linkIsMaster,
	output key_t encKey,
	output logic encValid,
	output logic authReq,
	output logic excluded
);
	typedef enum {ST_IDLE, ST_COMB_WAIT, ST_COMB_AUTH} st_t;
	typedef struct packed {
		st_t  st;
		key_t link, prevLink, pending, ownRand, encKey;
		ofs_t storedOfs;
		logic isMasterKey, prevIsMaster, haveInit, encValid, authReq, excluded;
		logic masterHeld;
		key_t masterKey;
		msg_t tMsg;
		key_t tData;
	} state_t;
	state_t s_reg, s_next;
	key_t curKey, overlay;
	ofs_t ciphering_offset;

	// the init key serves as link key until a unit or combination key is stored
	assign curKey = s_reg.haveInit ? initKey : s_reg.link;
	assign overlay = mixKey(curKey, randIn);
	// offset source picked by the stored flag
	assign ciphering_offset = s_reg.isMasterKey ? {masterAddr, masterAddr} : s_reg.storedOfs;

	always_comb begin
		s_next = s_reg;
		s_next.tMsg = MSG_NONE;
		s_next.tData = `LKD_ZERO_KEY;
		s_next.authReq = 1'b0;
		// authenticated offset only kept when not confirming a master key
		if (authDone && authOk && !authConfirm) begin
			s_next.storedOfs = authOffset;
		end
		unique case (s_reg.st)
			ST_IDLE: begin
				if (cmdUnitKey) begin
					s_next.tMsg = MSG_UNIT_KEY;
					s_next.tData = unitKey;
					s_next.link = unitKey;
					s_next.haveInit = 1'b0;
				end else if (cmdComb) begin
					// masking key is init key or present key
					s_next.ownRand = randIn;
					s_next.tMsg = MSG_COMB_RAND;
					s_next.tData = randIn ^ curKey;
					s_next.st = ST_COMB_WAIT;
				end else if (cmdMasterGen && isMaster) begin
					// stored combination random ownRand and fresh randIn, result held in masterKey, length 16
					// length argument zero-extended to key width on purpose
					s_next.masterKey = mixKey(s_reg.ownRand ^ key_t'(`LKD_MASTER_LEN), randIn);
					s_next.tMsg = MSG_MASTER_RAND;
					s_next.tData = randIn;
					s_next.masterHeld = 1'b1;
				end else if (cmdUseMaster && isMaster && s_reg.masterHeld) begin
					s_next.tMsg = MSG_USE_MASTER;
				end else if (cmdEncrypt && lenOk) begin
					// fresh key each activation, one key for all traffic
					s_next.encKey = mixKey(curKey ^ {ciphering_offset, ciphering_offset[31:0]}, randIn);
					s_next.encValid = 1'b1;
					if (isMaster) begin
						s_next.tMsg = MSG_ENC_RAND;
						s_next.tData = randIn;
					end
				end else if (cmdFallback && isMaster) begin
					s_next.tMsg = MSG_FALLBACK;
				end
				if (cmdEncrypt && !lenOk) begin
					s_next.excluded = 1'b1;
				end
				// master key dealt on the overlay after the random
				if (isMaster && s_reg.tMsg == MSG_MASTER_RAND) begin
					s_next.tMsg = MSG_MASTER_KEY;
					s_next.tData = s_reg.masterKey ^ mixKey(curKey, s_reg.tData);
				end
				// confirmation by authentication, one authReq pulse in the cycle after the masked key
				if (isMaster && s_reg.tMsg == MSG_MASTER_KEY) begin
					s_next.authReq = 1'b1;
				end
				// peer message or own master command orders the switch or fallback
				if (link.pMsg == MSG_USE_MASTER || (isMaster && cmdUseMaster && s_reg.masterHeld)) begin
					s_next.prevLink = curKey;
					s_next.prevIsMaster = s_reg.isMasterKey;
					s_next.link = s_reg.masterKey;
					s_next.isMasterKey = 1'b1;
					s_next.encValid = 1'b0;
				end
				if (link.pMsg == MSG_FALLBACK || (isMaster && cmdFallback)) begin
					s_next.link = s_reg.prevLink;
					s_next.isMasterKey = s_reg.prevIsMaster;
					s_next.encValid = 1'b0;
				end
				if (link.pMsg == MSG_UNIT_KEY) begin
					s_next.link = link.pData;
					s_next.isMasterKey = 1'b0;
					s_next.haveInit = 1'b0;
				end
				if (link.pMsg == MSG_MASTER_RAND) begin
					s_next.tData = overlay; // slave keeps the overlay
				end
				if (link.pMsg == MSG_MASTER_KEY) begin
					s_next.masterKey = link.pData ^ s_reg.tData;
					s_next.masterHeld = 1'b1;
				end
				if (link.pMsg == MSG_ENC_RAND && s_reg.isMasterKey) begin
					s_next.encKey = mixKey(curKey ^ {ciphering_offset, ciphering_offset[31:0]}, link.pData);
					s_next.encValid = 1'b1;
				end
			end
			ST_COMB_WAIT: begin
				if (link.pMsg == MSG_COMB_RAND) begin
					// own contribution xor recomputed peer contribution
					s_next.pending = mixKey(s_reg.ownRand, {80'h0, ownAddr})
						^ mixKey(link.pData ^ curKey, {80'h0, peerAddr});
					s_next.authReq = 1'b1;
					s_next.st = ST_COMB_AUTH;
				end
			end
			ST_COMB_AUTH: begin
				if (authDone) begin
					if (authOk) begin
						s_next.link = s_reg.pending;
						s_next.isMasterKey = 1'b0;
						s_next.haveInit = 1'b0;
					end
					s_next.st = ST_IDLE;
				end
			end
		endcase
	end

	// single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '{st: ST_IDLE, haveInit: 1'b1, tMsg: MSG_NONE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state flops
	assign link.dMsg = s_reg.tMsg;
	assign link.dData = s_reg.tData;
	assign linkKey = s_reg.link;
	assign linkIsMaster = s_reg.isMasterKey;
	assign encKey = s_reg.encKey;
	assign encValid = s_reg.encValid;
	assign authReq = s_reg.authReq;
	assign excluded = s_reg.excluded;
endmodule : lkd_device_end

// ===== core/lkd_peer_end.sv
// peer end: the other radio unit, slave-side counterpart of the device end without master key generation or encryption
`timescale 1ns/1ps
module lkd_peer_end
	import lkd_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link toward the device
	lkd_link_if.peer link,
	// link manager side
	input  wire logic cmdUnitKey,
	input  wire logic cmdComb,
	input  wire logic authDone,
	input  wire logic authOk,
	input  wire key_t initKey,
	input  wire key_t unitKey,
	input  wire key_t randIn,
	input  wire addr_t ownAddr,
	input  wire addr_t peerAddr,
	// results
	output key_t linkKey,
	output logic authReq
);
	typedef enum {ST_IDLE, ST_WAIT, ST_AUTH} st_t;
	typedef struct packed {
		st_t  st;
		key_t link, prevLink, pending, ownRand, overlay;
		logic haveInit, authReq, sentOwn;
		msg_t tMsg;
		key_t tData;
	} state_t;
	state_t s_reg, s_next;
	key_t curKey;

	assign curKey = s_reg.haveInit ? initKey : s_reg.link;

	always_comb begin
		s_next = s_reg;
		s_next.tMsg = MSG_NONE;
		s_next.tData = `LKD_ZERO_KEY;
		s_next.authReq = 1'b0;
		unique case (s_reg.st)
			ST_IDLE: begin
				if (cmdUnitKey) begin
					s_next.tMsg = MSG_UNIT_KEY;
					s_next.tData = unitKey;
					s_next.link = unitKey;
					s_next.haveInit = 1'b0;
				end else if (cmdComb || link.dMsg == MSG_COMB_RAND) begin
					s_next.ownRand = randIn;
					s_next.tMsg = MSG_COMB_RAND;
					s_next.tData = randIn ^ curKey;
					s_next.st = ST_WAIT;
					s_next.sentOwn = 1'b1;
					// answering the device: its random is on the link only this cycle
					if (link.dMsg == MSG_COMB_RAND) begin
						s_next.pending = mixKey(randIn, {80'h0, ownAddr})
							^ mixKey(link.dData ^ curKey, {80'h0, peerAddr});
						s_next.authReq = 1'b1;
						s_next.st = ST_AUTH;
					end
				end
				if (link.dMsg == MSG_UNIT_KEY) begin
					s_next.link = link.dData;
					s_next.haveInit = 1'b0;
				end
				if (link.dMsg == MSG_MASTER_RAND) begin
					s_next.overlay = mixKey(curKey, link.dData);
				end
				if (link.dMsg == MSG_MASTER_KEY) begin
					s_next.pending = link.dData ^ s_reg.overlay;
					s_next.authReq = 1'b1;
				end
				if (link.dMsg == MSG_USE_MASTER) begin
					s_next.prevLink = curKey;
					s_next.link = s_reg.pending;
					s_next.haveInit = 1'b0;
				end
				if (link.dMsg == MSG_FALLBACK) begin
					s_next.link = s_reg.prevLink;
				end
			end
			ST_WAIT: begin
				// a device random that arrived in the idle cycle went straight to ST_AUTH; here a later one is awaited
				if (link.dMsg == MSG_COMB_RAND || s_reg.sentOwn) begin
					s_next.sentOwn = 1'b0;
					if (link.dMsg == MSG_COMB_RAND) begin
						s_next.pending = mixKey(s_reg.ownRand, {80'h0, ownAddr})
							^ mixKey(link.dData ^ curKey, {80'h0, peerAddr});
						s_next.authReq = 1'b1;
						s_next.st = ST_AUTH;
					end
				end
			end
			ST_AUTH: begin
				if (authDone) begin
					if (authOk) begin
						s_next.link = s_reg.pending;
						s_next.haveInit = 1'b0;
					end
					s_next.st = ST_IDLE;
				end
			end
		endcase
	end

	// single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '{st: ST_IDLE, haveInit: 1'b1, tMsg: MSG_NONE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.pMsg = s_reg.tMsg;
	assign link.pData = s_reg.tData;
	assign linkKey = s_reg.link;
	assign authReq = s_reg.authReq;
endmodule : lkd_peer_end

// ===== bench/lkd_link_props.sv
// assertions on the message link between the two key derivation ends
`timescale 1ns/1ps
module lkd_link_props
	import lkd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link signals
	input wire msg_t dMsg,
	input wire key_t dData,
	input wire msg_t pMsg,
	input wire key_t pData
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// reset must leave the wire silent, so no stale key leaks out
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> dMsg == MSG_NONE && pMsg == MSG_NONE
		&& dData == '0 && pData == '0)
		else $error("link not quiet after reset");
	a_comb_reply: assert property (dMsg == MSG_COMB_RAND |=> pMsg == MSG_COMB_RAND)
		else $error("peer did not answer combination random");
	a_dev_pulse: assert property (dMsg != MSG_NONE |=> dMsg != $past(dMsg))
		else $error("device message held too long");
	a_peer_pulse: assert property (pMsg != MSG_NONE |=> pMsg == MSG_NONE)
		else $error("peer message held too long");
	a_key_follows: assert property (dMsg == MSG_MASTER_RAND |=> dMsg == MSG_MASTER_KEY)
		else $error("masked master key late");
	a_key_cause: assert property (dMsg == MSG_MASTER_KEY |-> $past(dMsg) == MSG_MASTER_RAND)
		else $error("master key sent without random");
	a_peer_slave: assert property (pMsg inside {MSG_NONE, MSG_UNIT_KEY, MSG_COMB_RAND})
		else $error("peer sent a master-only message");
	// slaves only obey group commands, they never answer them
	a_group_quiet: assert property (dMsg inside {MSG_ENC_RAND, MSG_USE_MASTER, MSG_FALLBACK}
		|=> pMsg == MSG_NONE [*2])
		else $error("peer answered a group command");
endmodule : lkd_link_props

// ===== bench/link_key_derivation_engine_test.sv
// self-checking bench joining the device end and the peer end
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nMismatch++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module link_key_derivation_engine_test import lkd_pkg::*;;
	typedef struct {logic [10:0] c; key_t uk; key_t exp;} row_t;
	logic        clk, rst, lenOk, isMaster, isM, encValid, dAuth, pAuth, excluded;
	logic [10:0] cmd;
	key_t        initKey, unitKey, dRand, pRand, dKey, pKey, encKey, old, oldP, kk [3];
	addr_t       aAddr, bAddr;
	ofs_t        ofs;
	int          nMismatch, nTests;
	row_t        rows [3];
	lkd_link_if link (.clk(clk));
	lkd_device_end lkd_device_end_inst (.clk(clk), .rst(rst), .link(link), .cmdUnitKey(cmd[0]),
		.cmdComb(cmd[1]), .cmdMasterGen(cmd[2]), .cmdUseMaster(cmd[3]), .cmdEncrypt(cmd[4]),
		.cmdFallback(cmd[5]), .authDone(cmd[6]), .authOk(cmd[7]), .authConfirm(cmd[8]),
		.lenOk(lenOk), .initKey(initKey), .unitKey(unitKey), .randIn(dRand), .ownAddr(aAddr),
		.peerAddr(bAddr), .masterAddr(aAddr), .authOffset(ofs), .isMaster(isMaster),
		.linkKey(dKey), .linkIsMaster(isM), .encKey(encKey), .encValid(encValid),
		.authReq(dAuth), .excluded(excluded));
	lkd_peer_end lkd_peer_end_inst (.clk(clk), .rst(rst), .link(link), .cmdUnitKey(cmd[9]),
		.cmdComb(cmd[10]), .authDone(cmd[6]), .authOk(cmd[7]), .initKey(initKey),
		.unitKey(~unitKey), .randIn(pRand), .ownAddr(bAddr), .peerAddr(aAddr),
		.linkKey(pKey), .authReq(pAuth));
	lkd_link_props lkd_link_props_inst (.clk(clk), .rst(rst), .dMsg(link.dMsg),
		.dData(link.dData), .pMsg(link.pMsg), .pData(link.pData));

	task endOfTest();
		$display("tests %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : endOfTest

	// one-cycle command pulse, launched just after an edge
	task fire(input logic [10:0] m);
		@(posedge clk);
		#1 cmd = m;
		@(posedge clk);
		#1 cmd = '0;
	endtask : fire

	// bounded wait: 0 device message, 1 peer message, 2 authentication request
	task waitFor(input int w, input msg_t m);
		int i;
		for (i = 0; i < 20; i++) begin
			if (w == 0 && link.dMsg === m || w == 1 && link.pMsg === m || w == 2 && dAuth === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		if (i == 20) begin
			nMismatch++;
			endOfTest();
		end
	endtask : waitFor

	// full combination exchange; ok chooses the authentication outcome
	task comb(input logic ok, input key_t dm, input key_t pm);
		old = dKey;
		oldP = pKey;
		dRand = dRand + 1;
		pRand = pRand - 3;
		fire(11'h002);
		waitFor(0, MSG_COMB_RAND);
		`CHK(link.dData, dRand ^ dm)
		waitFor(1, MSG_COMB_RAND);
		`CHK(link.pData, pRand ^ pm)
		`CHK(pAuth, 1'b1)
		waitFor(2, MSG_NONE);
		`CHK(dKey, old)
		fire(ok ? 11'h0c0 : 11'h040);
		repeat (2) @(posedge clk);
		#1;
		// a failed exchange leaves both old keys, which may already agree
		`CHK(dKey === pKey, ok || old === oldP)
		`CHK(dKey === old, !ok)
	endtask : comb

	task encr(input key_t r, input ofs_t o, output key_t k);
		dRand = r;
		ofs = o;
		fire(11'h010);
		waitFor(0, MSG_ENC_RAND);
		`CHK(link.dData, r)
		repeat (3) @(posedge clk);
		#1;
		k = encKey;
		`CHK(encValid, 1'b1)
	endtask : encr

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// main sequence: table of unit key cases, then awkward cases by hand
	initial begin
		rst = 1'b1;
		cmd = '0;
		lenOk = 1'b1;
		isMaster = 1'b1;
		initKey = {4{32'h0f1e_2d3c}};
		unitKey = '0;
		dRand = {4{32'h1357_9bdf}};
		pRand = {4{32'h2468_ace0}};
		aAddr = 48'h0011_2233_4455;
		bAddr = 48'h6677_8899_aabb;
		ofs = {3{32'hc0de_0001}};
		rows[0] = '{11'h001, {4{32'h1111_2222}}, {4{32'h1111_2222}}};
		rows[1] = '{11'h001, {4{32'hfedc_0001}}, {4{32'hfedc_0001}}};
		rows[2] = '{11'h200, {4{32'h1111_2222}}, ~{4{32'h1111_2222}}};
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		foreach (rows[n]) begin
			unitKey = rows[n].uk;
			fire(rows[n].c);
			waitFor(rows[n].c[0] ? 0 : 1, MSG_UNIT_KEY);
			`CHK(rows[n].c[0] ? link.dData : link.pData, rows[n].exp)
			repeat (3) @(posedge clk);
			#1;
			`CHK(rows[n].c[0] ? pKey : dKey, rows[n].exp)
		end
		// second reset in mid-run brings the init key back as current key
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(dKey, '0)
		`CHK(isM, 1'b0)
		`CHK(encValid, 1'b0)
		rst = 1'b0;
		comb(1'b0, initKey, initKey);
		comb(1'b1, initKey, initKey);
		comb(1'b1, dKey, pKey);
		// a slave-role unit must refuse master key generation
		isMaster = 1'b0;
		fire(11'h004);
		repeat (4) begin
			`CHK(link.dMsg == MSG_MASTER_RAND, 1'b0)
			@(posedge clk);
			#1;
		end
		isMaster = 1'b1;
		old = dKey;
		fire(11'h004);
		waitFor(0, MSG_MASTER_RAND);
		waitFor(0, MSG_MASTER_KEY);
		// confirming offset differs, it must not replace the stored one
		ofs = ~ofs;
		fire(11'h1c0);
		fire(11'h008);
		waitFor(0, MSG_USE_MASTER);
		repeat (2) @(posedge clk);
		#1;
		`CHK(isM, 1'b1)
		`CHK(pKey === dKey, 1'b1)
		encr(dRand, ofs, kk[0]);
		encr(dRand, ~ofs, kk[1]);
		`CHK(kk[0] === kk[1], 1'b1)
		encr(dRand + 5, ~ofs, kk[2]);
		`CHK(kk[2] === kk[1], 1'b0)
		lenOk = 1'b0;
		fire(11'h010);
		repeat (3) @(posedge clk);
		#1;
		`CHK(excluded, 1'b1)
		lenOk = 1'b1;
		fire(11'h020);
		waitFor(0, MSG_FALLBACK);
		repeat (2) @(posedge clk);
		#1;
		`CHK(isM, 1'b0)
		`CHK(dKey, old)
		// offset now comes from the stored authenticated offset
		encr(dRand, ofs, kk[0]);
		ofs = ~ofs;
		fire(11'h0c0);
		encr(dRand, ofs, kk[1]);
		`CHK(kk[0] === kk[1], 1'b1)
		ofs = ~ofs;
		fire(11'h0c0);
		encr(dRand, ofs, kk[2]);
		`CHK(kk[2] === kk[1], 1'b0)
		endOfTest();
	end
endmodule : link_key_derivation_engine_test
